//--- hdl/roc_pkg.sv
// Constants, register map and source codes for the relay output conditioner
package roc_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_ACT_DELAY = 4'h4;
  localparam logic [3:0] OFS_HOLD_DELAY = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // ==========================================================
  // Field positions
  localparam int CFG_SRC_LSB = 0;
  localparam int SRC_W = 5;
  localparam int CFG_POL_BIT = 8;
  localparam int CFG_FALLBACK_BIT = 9;
  localparam int DELAY_W = 16;
  localparam int ST_COND_BIT = 0;
  localparam int ST_LOGIC_BIT = 1;
  localparam int ST_RELAY_BIT = 2;
  localparam int ST_FIELDBUS_BIT = 3;
  localparam int ST_LINK_LOST_BIT = 4;

  // ==========================================================
  // Output source selection codes
  typedef enum logic [4:0] {
    SRC_UNASSIGNED = 5'h00,
    SRC_OPERATING_FAULT = 5'h01,
    SRC_DC_BUS_CHARGED = 5'h02,
    BRAKING_SOURCE = 5'h03,
    SRC_CURRENT_PRESENT = 5'h04,
    SRC_WARNING_GROUP1 = 5'h05,
    SRC_WARNING_GROUP2 = 5'h06,
    SRC_WARNING_GROUP3 = 5'h07,
    SRC_WARNING_GROUP4 = 5'h08,
    SRC_WARNING_GROUP5 = 5'h09,
    SRC_AI1_LOOP_LOSS = 5'h0A,
    SRC_AI3_LOOP_LOSS = 5'h0B,
    SRC_AI4_LOOP_LOSS = 5'h0C,
    SRC_AI5_LOOP_LOSS = 5'h0D,
    SRC_READY = 5'h0E,
    FALLBACK_SPEED_STATE = 5'h0F,
    SRC_SPEED_MAINTAINED = 5'h10,
    SRC_STOP_BY_TYPE = 5'h11,
    POSITION_REACHED_SOURCE = 5'h12
  } roc_source_type;

  localparam logic [4:0] SRC_MAX = 5'h12;
  localparam int STATUS_COND_W = 17;

  // ==========================================================
  // Reset values
  localparam logic [4:0] RST_SRC = 5'h01;
  localparam logic RST_POLARITY = 1'b1;
  localparam logic RST_FALLBACK = 1'b0;
  localparam logic [15:0] RST_ACT_DELAY = 16'h0000;
  localparam logic [15:0] RST_HOLD_DELAY = 16'h0000;

  // ==========================================================
  // Timing
  localparam int CLOCK_HZ = 25000000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES_DEFAULT = CLOCK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int TICK_CNT_W = 16;
  localparam int ACT_DELAY_MAX_MS = 60000;
  localparam int HOLD_DELAY_MAX_MS = 9999;
  localparam logic [15:0] ACT_DELAY_MAX = 16'(ACT_DELAY_MAX_MS);
  localparam logic [15:0] HOLD_DELAY_MAX = 16'(HOLD_DELAY_MAX_MS);

endpackage

//--- hdl/roc_delay_if.sv
// Interface between the conditioner and its delay stage
`timescale 1ns/1ns
`default_nettype none
interface roc_delay_if;
  logic tick;
  logic cond;
  logic [15:0] act_ms;
  logic [15:0] hold_ms;
  logic state;
  modport ctrl (output tick, output cond, output act_ms, output hold_ms, input state);
  modport timer (input tick, input cond, input act_ms, input hold_ms, output state);
endinterface
`default_nettype wire

//--- hdl/roc_delay_stage.sv
// Activation and holding delay stage for one logical condition
`timescale 1ns/1ns
`default_nettype none
module roc_delay_stage (
  input wire logic clock,
  input wire logic reset_n,
  roc_delay_if.timer dly
);
  logic state;
  logic [15:0] count;
  wire differs = dly.cond != state;
  wire [15:0] target = dly.cond ? dly.act_ms : dly.hold_ms;
  wire expired = count >= target;

  // ==========================================================
  // Timer
  // Count restarts whenever the condition falls back to the held state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= 1'b0;
      count <= 16'h0000;
    end else if (!differs) begin
      count <= 16'h0000; // RL14
    end else if (expired) begin
      state <= dly.cond; // RL3 RL7
      count <= 16'h0000;
    end else if (dly.tick) begin
      count <= count + 16'h0001; // RL14
    end
  end

  assign dly.state = state;
endmodule
`default_nettype wire

//--- hdl/roc_relay_conditioner.sv
// Relay output conditioner with AXI4-Lite register access
// Overview of operation
// RL1: Relay follows one selectable internal status condition.
// RL2: Selection also offers fallback speed, speed maintained, stop by type.
// RL3: Rising condition changes output after activation delay, up to 60000 ms.
// RL4: Operating-fault source forces activation delay to zero.
// RL5: Polarity 1 gives output high while true; polarity 0 output low.
// RL6: Operating-fault source locks polarity at 1; writes cannot change it.
// RL7: Falling condition releases output after holding delay, up to 9999 ms.
// RL8: Operating-fault source forces holding delay to zero.
// RL9: Fallback enable reads off whenever a source is assigned.
// RL10: Without fallback, a fieldbus link loss leaves the output unchanged.
// RL11: Unassigned output is set or cleared by the fieldbus output bit.
// RL12: Fallback on: follow fieldbus bit, and error resets output inactive.
// RL13: Source selection resets to the operating-fault condition.
// RL14: Delays count millisecond ticks; reverting condition cancels the pending change.
// RL15: Polarity is applied after both delay stages.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module roc_relay_conditioner #(
  parameter int unsigned TICK_CYCLES = roc_pkg::TICK_CYCLES_DEFAULT
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [3:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [3:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic OPERATING_FAULT,
  input wire logic [16:0] STATUS_COND,
  input wire logic FIELDBUS_OUTPUT_WORD_BIT,
  input wire logic FIELDBUS_LINK_LOST,
  input wire logic ERROR_TRIGGER,
  output logic RELAY_OUT
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_mapped(input logic [3:0] addr);
    return addr == roc_pkg::OFS_CONFIG || addr == roc_pkg::OFS_ACT_DELAY ||
           addr == roc_pkg::OFS_HOLD_DELAY || addr == roc_pkg::OFS_STATUS;
  endfunction

  // ==========================================================
  // Configuration state
  logic [4:0] source_sel;
  logic polarity;
  logic fallback_en;
  logic [15:0] relay_activation_delay;
  logic [15:0] relay_holding_delay;
  logic fieldbus_state;
  logic [15:0] tick_count;
  logic tick;

  // ==========================================================
  // Write channel state
  logic aw_full;
  logic w_full;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [3:0] ar_addr_unused;

  wire aw_take = AWVALID && AWREADY;
  wire w_take = WVALID && WREADY;
  wire b_done = BVALID && BREADY;
  wire wr_go = aw_full && w_full && !BVALID;
  wire next_aw_full = (aw_full || aw_take) && !wr_go;
  wire next_w_full = (w_full || w_take) && !wr_go;
  wire next_bvalid = wr_go || (BVALID && !BREADY);
  wire ar_take = ARVALID && ARREADY;
  wire next_rvalid = ar_take || (RVALID && !RREADY);

  // ==========================================================
  // Register write decode
  wire wr_config = wr_go && aw_addr == roc_pkg::OFS_CONFIG;
  wire wr_act = wr_go && aw_addr == roc_pkg::OFS_ACT_DELAY;
  wire wr_hold = wr_go && aw_addr == roc_pkg::OFS_HOLD_DELAY;

  wire [31:0] config_word = {22'h000000, fallback_en, polarity, 3'h0, source_sel};
  wire [31:0] config_merged = merge_bytes(config_word, w_data, w_strb);
  wire [4:0] config_src_req = config_merged[roc_pkg::CFG_SRC_LSB +: roc_pkg::SRC_W];
  // Unknown source codes leave the old selection in place
  wire [4:0] next_source = (config_src_req > roc_pkg::SRC_MAX) ? source_sel : config_src_req;
  wire next_is_fault = next_source == roc_pkg::SRC_OPERATING_FAULT;
  wire next_unassigned = next_source == roc_pkg::SRC_UNASSIGNED;
  wire next_polarity = next_is_fault ? 1'b1 : config_merged[roc_pkg::CFG_POL_BIT];
  wire next_fallback = next_unassigned && config_merged[roc_pkg::CFG_FALLBACK_BIT];

  wire [31:0] act_merged = merge_bytes({16'h0000, relay_activation_delay}, w_data, w_strb);
  wire [31:0] hold_merged = merge_bytes({16'h0000, relay_holding_delay}, w_data, w_strb);
  // Saturate instead of wrapping so an oversize value still means a long delay
  wire [15:0] next_act = (act_merged[31:16] != 16'h0000 ||
                          act_merged[15:0] > roc_pkg::ACT_DELAY_MAX) ?
                         roc_pkg::ACT_DELAY_MAX : act_merged[15:0];
  wire [15:0] next_hold = (hold_merged[31:16] != 16'h0000 ||
                           hold_merged[15:0] > roc_pkg::HOLD_DELAY_MAX) ?
                          roc_pkg::HOLD_DELAY_MAX : hold_merged[15:0];

  // ==========================================================
  // Source selection and condition path
  wire is_fault_src = source_sel == roc_pkg::SRC_OPERATING_FAULT;
  wire is_unassigned = source_sel == roc_pkg::SRC_UNASSIGNED;
  wire [18:0] cond_vec = {STATUS_COND, OPERATING_FAULT, 1'b0};
  wire selected_cond = (source_sel <= roc_pkg::SRC_MAX) ? cond_vec[source_sel] : 1'b0; // RL1 RL2

  roc_delay_if dly ();
  assign dly.tick = tick;
  assign dly.cond = selected_cond;
  assign dly.act_ms = is_fault_src ? 16'h0000 : relay_activation_delay; // RL4
  assign dly.hold_ms = is_fault_src ? 16'h0000 : relay_holding_delay; // RL8

  roc_delay_stage u_delay (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .dly(dly)
  );

  // Unassigned output bypasses the timers and takes the fieldbus state
  wire logical_state = is_unassigned ? fieldbus_state : dly.state; // RL11
  wire next_relay = polarity ? logical_state : !logical_state; // RL5 RL15

  // Fieldbus state: error reset only with fallback, else hold on link loss
  wire next_fieldbus = (fallback_en && ERROR_TRIGGER) ? 1'b0 : // RL12
                       FIELDBUS_LINK_LOST ? fieldbus_state : // RL10
                       FIELDBUS_OUTPUT_WORD_BIT; // RL11 RL12

  // ==========================================================
  // Read decode
  wire [31:0] status_word = {27'h0000000, FIELDBUS_LINK_LOST, fieldbus_state, RELAY_OUT,
                             logical_state, selected_cond};
  wire [31:0] read_word = (ARADDR == roc_pkg::OFS_CONFIG) ? config_word :
                          (ARADDR == roc_pkg::OFS_ACT_DELAY) ? {16'h0000, relay_activation_delay} :
                          (ARADDR == roc_pkg::OFS_HOLD_DELAY) ? {16'h0000, relay_holding_delay} :
                          (ARADDR == roc_pkg::OFS_STATUS) ? status_word : 32'h00000000;

  // ==========================================================
  // Millisecond tick
  wire tick_wrap = 32'(tick_count) >= TICK_CYCLES - 1;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      tick_count <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick_count <= tick_wrap ? 16'h0000 : tick_count + 16'h0001; // RL14
      tick <= tick_wrap;
    end
  end

  // ==========================================================
  // Write address and data capture
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      if (aw_take) begin
        aw_addr <= AWADDR;
      end
      if (w_take) begin
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
    end
  end

  // ==========================================================
  // Handshake outputs
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= roc_pkg::RESP_OKAY;
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RRESP <= roc_pkg::RESP_OKAY;
      RDATA <= 32'h00000000;
    end else begin
      AWREADY <= !next_aw_full && !next_bvalid;
      WREADY <= !next_w_full && !next_bvalid;
      BVALID <= next_bvalid;
      ARREADY <= !next_rvalid;
      RVALID <= next_rvalid;
      if (wr_go) begin
        BRESP <= is_mapped(aw_addr) ? roc_pkg::RESP_OKAY : roc_pkg::RESP_SLVERR;
      end
      if (ar_take) begin
        RDATA <= read_word;
        RRESP <= is_mapped(ARADDR) ? roc_pkg::RESP_OKAY : roc_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      source_sel <= roc_pkg::RST_SRC; // RL13
      polarity <= roc_pkg::RST_POLARITY;
      fallback_en <= roc_pkg::RST_FALLBACK;
    end else if (wr_config) begin
      source_sel <= next_source;
      polarity <= next_polarity; // RL6
      fallback_en <= next_fallback; // RL9
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      relay_activation_delay <= roc_pkg::RST_ACT_DELAY;
      relay_holding_delay <= roc_pkg::RST_HOLD_DELAY;
    end else begin
      if (wr_act) begin
        relay_activation_delay <= next_act; // RL3
      end
      if (wr_hold) begin
        relay_holding_delay <= next_hold; // RL7
      end
    end
  end

  // ==========================================================
  // Relay output
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      fieldbus_state <= 1'b0;
      RELAY_OUT <= 1'b0;
    end else begin
      fieldbus_state <= next_fieldbus;
      RELAY_OUT <= next_relay;
    end
  end

  assign ar_addr_unused = ARPROT[0] ? 4'h0 : {1'b0, AWPROT};

endmodule
`default_nettype wire

//--- dv/roc_relay_properties.sv
// Concurrent checks on the relay output conditioner ports
`timescale 1ns/1ns
`default_nettype none
module roc_relay_properties (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [3:0] AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic [3:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic OPERATING_FAULT,
  input wire logic FIELDBUS_OUTPUT_WORD_BIT,
  input wire logic FIELDBUS_LINK_LOST,
  input wire logic ERROR_TRIGGER,
  input wire logic RELAY_OUT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // ==========================================
  // Shadow of the configuration, kept from completed writes
  logic [3:0] aw_q;
  logic [3:0] ar_q;
  logic [31:0] w_q;
  logic [4:0] src_q;
  logic pol_q;
  logic fb_q;
  logic [1:0] age;
  wire logic [4:0] nsrc = w_q[4:0];
  wire logic cfg_wr = BVALID && BREADY && BRESP == 2'h0 && aw_q == 4'h0 && nsrc <= 5'h12;
  // Settled excludes the cycles where a write may be landing
  wire logic settled = age == 2'h3;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_q <= 4'h0;
      ar_q <= 4'h0;
      w_q <= 32'h0;
      src_q <= 5'h01;
      pol_q <= 1'b1;
      fb_q <= 1'b0;
      age <= 2'h0;
    end else begin
      if (AWVALID && AWREADY) aw_q <= AWADDR;
      if (WVALID && WREADY) w_q <= WDATA;
      if (ARVALID && ARREADY) ar_q <= ARADDR;
      if (cfg_wr) src_q <= nsrc;
      if (cfg_wr) pol_q <= (nsrc == 5'h01) | w_q[8];
      if (cfg_wr) fb_q <= (nsrc == 5'h00) & w_q[9];
      age <= (AWVALID || WVALID || BVALID) ? 2'h0 : (settled ? age : age + 2'h1);
    end
  end
  // ==========================================
  // Properties
  sequence link_lost_seq;
    src_q == 5'h00 && settled && FIELDBUS_LINK_LOST && !ERROR_TRIGGER
      ##1 FIELDBUS_LINK_LOST && !ERROR_TRIGGER;
  endsequence
  sequence read_taken_seq;
    ARVALID && ARREADY;
  endsequence
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  read_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read response dropped early");
  read_answer_a: assert property (read_taken_seq |=> RVALID)
    else $error("read not answered");
  read_block_a: assert property (RVALID |-> !ARREADY)
    else $error("address taken during read answer");
  write_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken during response");
  fallback_forced_a: assert property (RVALID && ar_q == 4'h0 && RDATA[4:0] != 5'h00 |-> !RDATA[9])
    else $error("fallback reads on with assigned source");
  fault_follow_a: assert property (settled && src_q == 5'h01 |-> ##2 (!settled || RELAY_OUT == $past(OPERATING_FAULT, 2)))
    else $error("fault source not passed straight through");
  field_follow_a: assert property (settled && src_q == 5'h00 && !FIELDBUS_LINK_LOST && !(fb_q && ERROR_TRIGGER)
    |-> ##2 (!settled || RELAY_OUT == ($past(FIELDBUS_OUTPUT_WORD_BIT, 2) ~^ pol_q)))
    else $error("relay not following fieldbus bit");
  error_reset_a: assert property (settled && src_q == 5'h00 && fb_q && ERROR_TRIGGER
    |-> ##2 (!settled || RELAY_OUT == !pol_q))
    else $error("error did not reset relay");
  link_hold_a: assert property (link_lost_seq |=> (!settled || $stable(RELAY_OUT)))
    else $error("relay changed with link lost");
endmodule
bind roc_relay_conditioner roc_relay_properties i_props (.CLOCK, .RESET_N, .AWADDR, .AWVALID,
  .AWREADY, .WDATA, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
  .RDATA, .RRESP, .RVALID, .RREADY, .OPERATING_FAULT, .FIELDBUS_OUTPUT_WORD_BIT,
  .FIELDBUS_LINK_LOST, .ERROR_TRIGGER, .RELAY_OUT);
`default_nettype wire

//--- dv/roc_fieldbus_master.sv
// Fieldbus master model driving the relay command bit
`timescale 1ns/1ns
`default_nettype none
module roc_fieldbus_master (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cmd_bit,
  input wire logic cmd_lost,
  output logic fb_bit,
  output logic fb_lost
);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fb_bit <= 1'b0;
      fb_lost <= 1'b0;
    end else begin
      fb_lost <= cmd_lost;
      // A dead link carries no valid bit, so it toggles instead of holding
      fb_bit <= cmd_lost ? !fb_bit : cmd_bit;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the relay output conditioner
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic CLOCK = 1'b0;
  logic RESET_N = 1'b0;
  logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hF;
  logic [31:0] WDATA = 32'h0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic OPERATING_FAULT = 1'b0, ERROR_TRIGGER = 1'b0, cmd_bit = 1'b0, cmd_lost = 1'b0;
  logic [16:0] STATUS_COND = 17'h00000;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, RELAY_OUT, fb_bit, fb_lost;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA, r, mk;
  logic [31:0] exp_q[$], msk_q[$];
  int num_errors = 0, checks_done = 0, cycles = 0, seed = 32'hF500B835;
  always #20 CLOCK = ~CLOCK;
  roc_relay_conditioner #(.TICK_CYCLES(4)) i_dut (.CLOCK, .RESET_N, .AWADDR, .AWPROT(3'h0),
    .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
    .ARPROT(3'h0), .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .OPERATING_FAULT,
    .STATUS_COND, .FIELDBUS_OUTPUT_WORD_BIT(fb_bit), .FIELDBUS_LINK_LOST(fb_lost),
    .ERROR_TRIGGER, .RELAY_OUT);
  roc_fieldbus_master i_fbm (.clock(CLOCK), .reset_n(RESET_N), .cmd_bit, .cmd_lost, .fb_bit,
    .fb_lost);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // Bus tasks: readiness is judged at the falling edge, hand-over at the next rise
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge CLOCK);
      ta = ta | (AWVALID && AWREADY);
      tw = tw | (WVALID && WREADY);
      @(posedge CLOCK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
    end
    BREADY <= 1'b1;
    do @(negedge CLOCK); while (BVALID !== 1'b1);
    chk("BRESP", {30'h0, roc_pkg::RESP_OKAY}, {30'h0, BRESP});
    @(posedge CLOCK);
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    ARADDR <= a;
    ARVALID <= 1'b1;
    do @(negedge CLOCK); while (ARREADY !== 1'b1);
    @(posedge CLOCK);
    ARVALID <= 1'b0;
    RREADY <= 1'b1;
    do @(negedge CLOCK); while (RVALID !== 1'b1);
    @(posedge CLOCK);
    RREADY <= 1'b0;
  endtask
  task automatic rly(input int n, input logic e);
    repeat (n) @(posedge CLOCK);
    @(negedge CLOCK);
    chk("RELAY_OUT", {31'h0, e}, {31'h0, RELAY_OUT});
    @(posedge CLOCK);
  endtask
  always @(negedge CLOCK) begin
    if (RVALID === 1'b1 && RREADY === 1'b1 && exp_q.size() > 0) begin
      mk = msk_q.pop_front();
      chk("RDATA", exp_q.pop_front(), RDATA & mk);
      chk("RRESP", {30'h0, roc_pkg::RESP_OKAY}, {30'h0, RRESP});
    end
  end
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge CLOCK);
    RESET_N <= 1'b1;
    @(posedge CLOCK);
    rd(roc_pkg::OFS_CONFIG, 32'h00000101, 32'h0000031F);
    rd(roc_pkg::OFS_ACT_DELAY, 32'h0, 32'h0000FFFF);
    rd(roc_pkg::OFS_HOLD_DELAY, 32'h0, 32'h0000FFFF);
    OPERATING_FAULT <= 1'b1;
    rly(3, 1'b1);
    wr(roc_pkg::OFS_ACT_DELAY, 32'h5);
    wr(roc_pkg::OFS_HOLD_DELAY, 32'h5);
    wr(roc_pkg::OFS_CONFIG, 32'h00000001);
    rd(roc_pkg::OFS_CONFIG, 32'h00000101, 32'h0000031F);
    rd(roc_pkg::OFS_STATUS, 32'h5, 32'h5);
    OPERATING_FAULT <= 1'b0;
    rly(3, 1'b0);
    OPERATING_FAULT <= 1'b1;
    rly(3, 1'b1);
    wr(roc_pkg::OFS_ACT_DELAY, 32'h0000FFFF);
    wr(roc_pkg::OFS_HOLD_DELAY, 32'h0000FFFF);
    rd(roc_pkg::OFS_ACT_DELAY, 32'h0000EA60, 32'h0000FFFF);
    rd(roc_pkg::OFS_HOLD_DELAY, 32'h0000270F, 32'h0000FFFF);
    wr(roc_pkg::OFS_ACT_DELAY, 32'h0);
    wr(roc_pkg::OFS_HOLD_DELAY, 32'h0);
    for (int c = 2; c <= 18; c++) begin
      wr(roc_pkg::OFS_CONFIG, 32'h00000100 | 32'(c));
      r = $random(seed);
      STATUS_COND <= r[16:0];
      rly(3, r[c-2]);
    end
    wr(roc_pkg::OFS_CONFIG, 32'h00000002);
    STATUS_COND <= 17'h00001;
    rly(3, 1'b0);
    STATUS_COND <= 17'h00000;
    rly(3, 1'b1);
    wr(roc_pkg::OFS_CONFIG, 32'h00000302);
    rd(roc_pkg::OFS_CONFIG, 32'h00000102, 32'h0000031F);
    wr(roc_pkg::OFS_CONFIG, 32'h0000011F);
    rd(roc_pkg::OFS_CONFIG, 32'h00000102, 32'h0000031F);
    wr(roc_pkg::OFS_ACT_DELAY, 32'h3);
    wr(roc_pkg::OFS_HOLD_DELAY, 32'h2);
    STATUS_COND <= 17'h00001;
    rly(8, 1'b0);
    rly(8, 1'b1);
    STATUS_COND <= 17'h00000;
    rly(4, 1'b1);
    rly(8, 1'b0);
    STATUS_COND <= 17'h00001;
    rly(4, 1'b0);
    STATUS_COND <= 17'h00000;
    rly(16, 1'b0);
    wr(roc_pkg::OFS_CONFIG, 32'h00000002);
    STATUS_COND <= 17'h00001;
    rly(8, 1'b1);
    rly(8, 1'b0);
    wr(roc_pkg::OFS_CONFIG, 32'h00000300);
    rd(roc_pkg::OFS_CONFIG, 32'h00000300, 32'h0000031F);
    cmd_bit <= 1'b1;
    rly(4, 1'b1);
    cmd_bit <= 1'b0;
    rly(4, 1'b0);
    cmd_bit <= 1'b1;
    ERROR_TRIGGER <= 1'b1;
    rly(4, 1'b0);
    ERROR_TRIGGER <= 1'b0;
    rly(4, 1'b1);
    wr(roc_pkg::OFS_CONFIG, 32'h00000100);
    cmd_lost <= 1'b1;
    rly(4, 1'b1);
    ERROR_TRIGGER <= 1'b1;
    rly(4, 1'b1);
    cmd_lost <= 1'b0;
    ERROR_TRIGGER <= 1'b0;
    cmd_bit <= 1'b0;
    rly(4, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
